// file: dv/pad_board_model.sv
`timescale 1ns/1ps
// board side of the five pads: weak pull-up everywhere, optional board drivers
module pad_board_model (
    input  wire logic [4:0] bd_val_in,              // board drive values, a1 a2 a3 b3 b4
    input  wire logic [4:0] bd_en_in,               // board drive enables
    input  wire logic       port_a_bit1_pin_out,    // chip drive value
    input  wire logic       port_a_bit1_pin_oe_out, // chip drive enable
    input  wire logic       port_a_bit2_pin_out,    // chip drive value
    input  wire logic       port_a_bit2_pin_oe_out, // chip drive enable
    input  wire logic       port_a_bit3_pin_out,    // chip drive value
    input  wire logic       port_a_bit3_pin_oe_out, // chip drive enable
    input  wire logic       port_b_bit3_pin_out,    // chip drive value
    input  wire logic       port_b_bit3_pin_oe_out, // chip drive enable
    input  wire logic       port_b_bit4_pin_out,    // chip drive value
    input  wire logic       port_b_bit4_pin_oe_out, // chip drive enable
    output logic            port_a_bit1_pin_in,     // resolved pad level
    output logic            port_a_bit2_pin_in,     // resolved pad level
    output logic            port_a_bit3_pin_in,     // resolved pad level
    output logic            port_b_bit3_pin_in,     // resolved pad level
    output logic            port_b_bit4_pin_in      // resolved pad level
);
    logic [4:0] drv;
    logic [4:0] oe;
    logic [4:0] lvl;
    // chip wins over the board; released pads take the board drive or float up, never a stale value
    assign drv = {port_b_bit4_pin_out, port_b_bit3_pin_out, port_a_bit3_pin_out, port_a_bit2_pin_out,
                  port_a_bit1_pin_out};
    assign oe  = {port_b_bit4_pin_oe_out, port_b_bit3_pin_oe_out, port_a_bit3_pin_oe_out,
                  port_a_bit2_pin_oe_out, port_a_bit1_pin_oe_out};
    assign lvl = (oe & drv) | (~oe & ((bd_en_in & bd_val_in) | ~bd_en_in));
    assign {port_b_bit4_pin_in, port_b_bit3_pin_in, port_a_bit3_pin_in, port_a_bit2_pin_in,
            port_a_bit1_pin_in} = lvl;
endmodule // pad_board_model

// file: dv/port_a_low_pin_function_mux_chk.sv
`timescale 1ns/1ps
module port_a_low_pin_function_mux_chk #(
    parameter bit USB_PRESENT = 1'h1                              // part has the usb block
) (
    input wire logic        clk_in, sys_rst_in, ce_in, // clock, reset, enable
    input wire logic [15:0] port_a_low_config_register_in, // pin config fields
    input wire logic [3:0]  port_b_bit3_cfg_in, // b3 config field
    input wire logic [7:0]  timer2_remap_register_in, serial2_spi_config_in,
    input wire logic [2:0]  timer2_output_enable_register_in,
    input wire logic [1:0]  serial2_mode_field_in,
    input wire logic        timer2_channel2_in, timer2_channel3_in, timer2_channel4_in, serial2_twi_data_in,
    input wire logic        port_a_bit1_pin_in, port_a_bit3_pin_in, usb_plus_line_out, timer2_channel3_out,
    input wire logic        serial2_spi_slave_select_n_out, port_a_bit1_pin_out, port_a_bit1_pin_oe_out,
    input wire logic        port_a_bit2_pin_out, port_a_bit2_pin_oe_out, port_a_bit3_pin_out,
    input wire logic        port_a_bit3_pin_oe_out, port_b_bit3_pin_out, port_b_bit3_pin_oe_out
);
    logic [3:0] f1, f2, f3;
    logic [2:0] en;
    logic [7:0] rm;
    assign {f3, f2, f1} = port_a_low_config_register_in[15:4];
    assign en = timer2_output_enable_register_in;
    assign rm = timer2_remap_register_in;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // drive paths answer one edge after their selects
    usb_select_a: assert property (ce_in && f1 == 4'h0 && USB_PRESENT
        |=> usb_plus_line_out && !port_a_bit1_pin_oe_out) else $error("usb select wrong");
    ch3_drive_a: assert property (ce_in && f1 == 4'h9 && en[1] && !rm[6]
        |=> port_a_bit1_pin_oe_out && port_a_bit1_pin_out == $past(timer2_channel3_in))
        else $error("ch3 drive wrong");
    ch4_drive_a: assert property (ce_in && f2 == 4'h9 && en[2] && !rm[7]
        |=> port_a_bit2_pin_oe_out && port_a_bit2_pin_out == $past(timer2_channel4_in))
        else $error("ch4 drive wrong");
    ch2_drive_a: assert property (ce_in && f3 == 4'h9 && en[0] && !rm[5]
        |=> port_a_bit3_pin_oe_out && port_a_bit3_pin_out == $past(timer2_channel2_in))
        else $error("ch2 drive wrong");
    twi_data_a: assert property (ce_in && serial2_mode_field_in == 2'h3 && f1 == 4'hd && (!en[1] || rm[6])
        |=> !port_a_bit1_pin_out && port_a_bit1_pin_oe_out == !$past(serial2_twi_data_in))
        else $error("twi data wrong");
    ch3_remap_a: assert property (ce_in && rm[6] && en[1] && port_b_bit3_cfg_in == 4'h9
        |=> port_b_bit3_pin_oe_out && port_b_bit3_pin_out == $past(timer2_channel3_in))
        else $error("ch3 remap wrong");
    gpio_quiet_a: assert property (ce_in && f3 == 4'h4 |=> !port_a_bit3_pin_oe_out)
        else $error("input pin driven");
    // pad paths: four edges through the filter plus one at the output flop, seven samples leave margin
    ssel_sync_a: assert property ((ce_in && serial2_mode_field_in == 2'h2 && !serial2_spi_config_in[4]
        && !port_a_bit3_pin_in) [*7] |-> !serial2_spi_slave_select_n_out) else $error("slave select lost");
    cap3_sync_a: assert property ((ce_in && !rm[6] && $stable(port_a_bit1_pin_in)) [*7]
        |-> timer2_channel3_out == port_a_bit1_pin_in) else $error("ch3 capture wrong");
    cover property (usb_plus_line_out);
    cover property (!serial2_spi_slave_select_n_out);
    cover property (port_b_bit3_pin_oe_out);
endmodule // port_a_low_pin_function_mux_chk
bind port_a_low_pin_function_mux port_a_low_pin_function_mux_chk #(.USB_PRESENT(USB_PRESENT)) chk_i (.*);

// file: dv/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic clk_in = 1'h0, sys_rst_in = 1'h1, ce_in = 1'h1;
    logic [15:0] port_a_low_config_register_in = 16'h4444;
    logic [3:0] port_b_bit3_cfg_in = 4'h4, port_b_bit4_cfg_in = 4'h4;
    logic [7:0] timer2_remap_register_in = 8'h00, serial2_spi_config_in = 8'h00;
    logic [2:0] timer2_output_enable_register_in = 3'h0, interrupt_c_pin_select_in = 3'h0;
    logic [2:0] interrupt_d_pin_select_in = 3'h0;
    logic [1:0] serial2_mode_field_in = 2'h0;
    logic [4:0] gpio_data_in = 5'h00, bd_val_in = 5'h00, bd_en_in = 5'h00, gpio_level_out;
    logic timer2_channel2_in = 1'h0, timer2_channel3_in = 1'h0, timer2_channel4_in = 1'h0;
    logic serial2_twi_data_in = 1'h1, serial2_twi_clock_in = 1'h1;
    logic serial2_spi_slave_out_master_in_in = 1'h0, serial2_spi_clock_in = 1'h0;
    logic timer2_channel2_out, timer2_channel3_out, timer2_channel4_out, serial2_twi_data_out;
    logic serial2_twi_clock_out, serial2_spi_slave_out_master_in_out, serial2_spi_clock_out;
    logic serial2_spi_slave_select_n_out, external_interrupt_c_out, external_interrupt_d_out, usb_plus_line_out;
    logic port_a_bit1_pin_in, port_a_bit1_pin_out, port_a_bit1_pin_oe_out;
    logic port_a_bit2_pin_in, port_a_bit2_pin_out, port_a_bit2_pin_oe_out;
    logic port_a_bit3_pin_in, port_a_bit3_pin_out, port_a_bit3_pin_oe_out;
    logic port_b_bit3_pin_in, port_b_bit3_pin_out, port_b_bit3_pin_oe_out;
    logic port_b_bit4_pin_in, port_b_bit4_pin_out, port_b_bit4_pin_oe_out;
    int err_total = 0;
    int n_compared = 0;
    port_a_low_pin_function_mux port_a_low_pin_function_mux_i (.*);
    pad_board_model pad_board_model_i (.*);
    initial forever #2 clk_in = ~clk_in;
    // outputs are read 1 ns after an edge, once that edge's updates have landed
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog: the sequence needs under a hundred cycles
    initial begin
        #40000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        wt(12);
        sys_rst_in <= 1'h0;
        wt(1);
        `CHK("oe_rst", 3'h0, {port_a_bit1_pin_oe_out, port_a_bit2_pin_oe_out, port_a_bit3_pin_oe_out})
        `CHK("ssel_rst", 1'h1, serial2_spi_slave_select_n_out)
        port_a_low_config_register_in <= 16'h4404;
        wt(2);
        `CHK("usb", 2'h2, {usb_plus_line_out, port_a_bit1_pin_oe_out})
        $display("end of usb test");
        // timer drives on all three pins, both output levels
        port_a_low_config_register_in <= 16'h9994;
        timer2_output_enable_register_in <= 3'h7;
        for (int v = 0; v < 2; v++) begin
            {timer2_channel2_in, timer2_channel4_in} <= {2{v[0]}};
            timer2_channel3_in <= ~v[0];
            wt(2);
            `CHK("a1_ch3", {1'h1, ~v[0]}, {port_a_bit1_pin_oe_out, port_a_bit1_pin_out})
            `CHK("a2_ch4", {1'h1, v[0]}, {port_a_bit2_pin_oe_out, port_a_bit2_pin_out})
            `CHK("a3_ch2", {1'h1, v[0]}, {port_a_bit3_pin_oe_out, port_a_bit3_pin_out})
        end
        // remap moves the ch3 and ch4 drives to port b, port a left with no claimant
        timer2_remap_register_in <= 8'he0;
        {port_b_bit3_cfg_in, port_b_bit4_cfg_in} <= 8'h99;
        wt(2);
        `CHK("a1_off", 1'h0, port_a_bit1_pin_oe_out)
        `CHK("a3_off", 1'h0, port_a_bit3_pin_oe_out)
        `CHK("b3_ch3", 2'h2, {port_b_bit3_pin_oe_out, port_b_bit3_pin_out})
        `CHK("b4_ch4", 2'h3, {port_b_bit4_pin_oe_out, port_b_bit4_pin_out})
        $display("end of timer drive test");
        // captures follow the remap; patterns differ between port a and b
        port_a_low_config_register_in <= 16'h4444;
        {port_b_bit3_cfg_in, port_b_bit4_cfg_in} <= 8'h44;
        bd_en_in <= 5'h1f;
        bd_val_in <= 5'h0a;
        wt(8);
        `CHK("cap3_b3", 1'h1, timer2_channel3_out)
        `CHK("cap4_b4", 1'h0, timer2_channel4_out)
        timer2_remap_register_in <= 8'h00;
        bd_val_in <= 5'h15;
        wt(8);
        `CHK("cap3_a1", 1'h1, timer2_channel3_out)
        `CHK("cap4_a2", 1'h0, timer2_channel4_out)
        `CHK("cap2_a3", 1'h1, timer2_channel2_out)
        for (int i = 0; i < 5; i++) begin
            interrupt_c_pin_select_in <= 3'(i);
            interrupt_d_pin_select_in <= 3'(4 - i);
            wt(2);
            `CHK("irq_c", bd_val_in[i], external_interrupt_c_out)
            `CHK("irq_d", bd_val_in[4 - i], external_interrupt_d_out)
        end
        $display("end of capture test");
        // plain gpio: push-pull, open-drain released, pulled input
        port_a_low_config_register_in <= 16'h8514;
        gpio_data_in <= 5'h03;
        wt(8);
        `CHK("a1_pp", 2'h3, {port_a_bit1_pin_oe_out, port_a_bit1_pin_out})
        `CHK("a2_od", 2'h0, {port_a_bit2_pin_oe_out, port_a_bit3_pin_oe_out})
        `CHK("level", 5'h15, gpio_level_out)
        $display("end of gpio test");
        // twi: ch3 clash avoided by remap, ch4 by disabled output; board stretches clock
        serial2_mode_field_in <= 2'h3;
        port_a_low_config_register_in <= 16'h4dd4;
        timer2_output_enable_register_in <= 3'h2;
        timer2_remap_register_in <= 8'h40;
        serial2_twi_data_in <= 1'h0;
        bd_en_in <= 5'h02;
        bd_val_in <= 5'h00;
        wt(8);
        `CHK("sda_low", 2'h2, {port_a_bit1_pin_oe_out, port_a_bit1_pin_out})
        `CHK("scl_rel", 1'h0, port_a_bit2_pin_oe_out)
        `CHK("twi_in", 2'h0, {serial2_twi_data_out, serial2_twi_clock_out})
        {serial2_twi_data_in, serial2_twi_clock_in} <= 2'h2;
        bd_en_in <= 5'h00;
        wt(8);
        `CHK("scl_low", 2'h2, {port_a_bit2_pin_oe_out, port_a_bit2_pin_out})
        `CHK("sda_up", 2'h1, {port_a_bit1_pin_oe_out, serial2_twi_data_out})
        $display("end of twi test");
        // spi slave then master
        serial2_mode_field_in <= 2'h2;
        port_a_low_config_register_in <= 16'h4494;
        timer2_output_enable_register_in <= 3'h0;
        timer2_remap_register_in <= 8'h00;
        serial2_spi_slave_out_master_in_in <= 1'h1;
        bd_en_in <= 5'h06;
        bd_val_in <= 5'h02;
        wt(8);
        `CHK("miso_drv", 2'h3, {port_a_bit1_pin_oe_out, port_a_bit1_pin_out})
        `CHK("sclk_in", 1'h1, serial2_spi_clock_out)
        `CHK("ssel_in", 1'h0, serial2_spi_slave_select_n_out)
        serial2_spi_config_in <= 8'h10;
        port_a_low_config_register_in <= 16'h4944;
        serial2_spi_clock_in <= 1'h1;
        bd_en_in <= 5'h01;
        bd_val_in <= 5'h01;
        wt(8);
        `CHK("sclk_drv", 2'h3, {port_a_bit2_pin_oe_out, port_a_bit2_pin_out})
        `CHK("miso_in", 1'h1, serial2_spi_slave_out_master_in_out)
        `CHK("ssel_idle", 1'h1, serial2_spi_slave_select_n_out)
        $display("end of spi test");
        tally_and_finish();
    end
endmodule // tb

// file: src/pin_input_sync.sv
`timescale 1ns/1ps
module pin_input_sync (
    input  wire logic clk_in,     // system clock
    input  wire logic sys_rst_in, // synchronous reset, high
    input  wire logic ce_in,      // clock enable
    pin_sync_if.sync  pins        // raw in, level out
);
    genvar i;
    generate
        for (i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin : g_bit
            logic [pin_mux_pkg::SYNC_STAGES-1:0] stage;
            logic [pin_mux_pkg::SYNC_STAGES-1:0] next_stage;
            logic                                 held;
            logic                                 next_held;
            // stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
            always_comb begin
                next_stage = {stage[1:0], pins.raw[i]};
                next_held  = (stage[1] == stage[2]) ? stage[2] : held;
            end
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    stage <= '0;
                    held  <= 1'h0;
                end else if (ce_in) begin
                    stage <= next_stage;
                    held  <= next_held;
                end
            end
            assign pins.level[i] = held;
        end
    endgenerate
endmodule // pin_input_sync

// file: src/pin_mux_pkg.sv
package pin_mux_pkg;
    // pin indices inside the synchronised level vector
    localparam int NUM_PINS     = 5;
    localparam int PIN_A1       = 0;
    localparam int PIN_A2       = 1;
    localparam int PIN_A3       = 2;
    localparam int PIN_B3       = 3;
    localparam int PIN_B4       = 4;
    localparam int SYNC_STAGES  = 3;

    // port a low config register field positions
    localparam int CFG_W        = 4;
    localparam int CFG_BIT1_LSB = 4;
    localparam int CFG_BIT2_LSB = 8;
    localparam int CFG_BIT3_LSB = 12;

    // per-pin config field encodings
    localparam logic [3:0] CFG_ANALOG  = 4'h0;
    localparam logic [3:0] CFG_OUT_PP  = 4'h1;
    localparam logic [3:0] CFG_INPUT   = 4'h4;
    localparam logic [3:0] CFG_OUT_OD  = 4'h5;
    localparam logic [3:0] CFG_IN_PULL = 4'h8;
    localparam logic [3:0] CFG_ALT_OUT = 4'h9;
    localparam logic [3:0] CFG_ALT_OD  = 4'hd;

    // timer 2 remap register bit positions
    localparam int REMAP_CH2 = 5;
    localparam int REMAP_CH3 = 6;
    localparam int REMAP_CH4 = 7;

    // timer 2 output enable vector positions
    localparam int TEN_CH2 = 0;
    localparam int TEN_CH3 = 1;
    localparam int TEN_CH4 = 2;

    // serial controller 2 mode field and spi config
    localparam logic [1:0] MODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_UART = 2'h1;
    localparam logic [1:0] MODE_SPI  = 2'h2;
    localparam logic [1:0] MODE_TWI  = 2'h3;
    localparam int SPI_MASTER_BIT    = 4;

    // values after reset
    localparam logic [4:0] PIN_OUT_RST = 5'h00;
    localparam logic [4:0] PIN_OE_RST  = 5'h00;
    localparam logic       IDLE_HIGH   = 1'h1;
    localparam logic       IDLE_LOW    = 1'h0;
endpackage

// file: src/pin_sync_if.sv
`timescale 1ns/1ps
interface pin_sync_if;
    logic [pin_mux_pkg::NUM_PINS-1:0] raw;   // pad levels, asynchronous
    logic [pin_mux_pkg::NUM_PINS-1:0] level; // filtered, clk_in domain
    modport src  (output raw, input level);
    modport sync (input raw, output level);
endinterface

// file: src/port_a_low_pin_function_mux.sv
`timescale 1ns/1ps
module port_a_low_pin_function_mux #(
    parameter bit USB_PRESENT = 1'b1                             // part has the usb block
) (
    input  wire logic        clk_in, // 250 MHz system clock
    input  wire logic        sys_rst_in, // synchronous reset, high
    input  wire logic        ce_in, // clock enable, freezes state
    // configuration
    input  wire logic [15:0] port_a_low_config_register_in, // bit0..bit3 config fields
    input  wire logic [3:0]  port_b_bit3_cfg_in, // port b bit3 config field
    input  wire logic [3:0]  port_b_bit4_cfg_in, // port b bit4 config field
    input  wire logic [7:0]  timer2_remap_register_in, // remap bits 7:5 used
    input  wire logic [2:0]  timer2_output_enable_register_in, // ch2, ch3, ch4 enables
    input  wire logic [1:0]  serial2_mode_field_in, // serial 2 mode
    input  wire logic [7:0]  serial2_spi_config_in, // bit4 selects master
    input  wire logic [2:0]  interrupt_c_pin_select_in, // pin index for irq c
    input  wire logic [2:0]  interrupt_d_pin_select_in, // pin index for irq d
    // gpio data
    input  wire logic [4:0]  gpio_data_in, // output data per pin
    output logic      [4:0]  gpio_level_out, // synchronised pin levels
    // peripheral outputs toward pins
    input  wire logic        timer2_channel2_in, // timer ch2 output
    input  wire logic        timer2_channel3_in, // timer ch3 output
    input  wire logic        timer2_channel4_in, // timer ch4 output
    input  wire logic        serial2_twi_data_in, // twi data, 0 pulls low
    input  wire logic        serial2_twi_clock_in, // twi clock, 0 pulls low
    input  wire logic        serial2_spi_slave_out_master_in_in, // slave data out
    input  wire logic        serial2_spi_clock_in, // master clock out
    // peripheral inputs from pins
    output logic             timer2_channel2_out, // timer ch2 capture input
    output logic             timer2_channel3_out, // timer ch3 capture input
    output logic             timer2_channel4_out, // timer ch4 capture input
    output logic             serial2_twi_data_out, // twi data seen on pin
    output logic             serial2_twi_clock_out, // twi clock seen on pin
    output logic             serial2_spi_slave_out_master_in_out, // master data in
    output logic             serial2_spi_clock_out, // slave clock in
    output logic             serial2_spi_slave_select_n_out, // slave select, low active
    output logic             external_interrupt_c_out, // irq c source level
    output logic             external_interrupt_d_out, // irq d source level
    output logic             usb_plus_line_out, // usb d+ owns bit1 pad
    // pads
    input  wire logic        port_a_bit1_pin_in, // pad level
    output logic             port_a_bit1_pin_out, // pad drive value
    output logic             port_a_bit1_pin_oe_out, // high while driving
    input  wire logic        port_a_bit2_pin_in, // pad level
    output logic             port_a_bit2_pin_out, // pad drive value
    output logic             port_a_bit2_pin_oe_out, // high while driving
    input  wire logic        port_a_bit3_pin_in, // pad level
    output logic             port_a_bit3_pin_out, // pad drive value
    output logic             port_a_bit3_pin_oe_out, // high while driving
    input  wire logic        port_b_bit3_pin_in, // pad level
    output logic             port_b_bit3_pin_out, // pad drive value
    output logic             port_b_bit3_pin_oe_out, // high while driving
    input  wire logic        port_b_bit4_pin_in, // pad level
    output logic             port_b_bit4_pin_out, // pad drive value
    output logic             port_b_bit4_pin_oe_out // high while driving
);
    // short pin indices for the decode below
    localparam int A1 = pin_mux_pkg::PIN_A1;
    localparam int A2 = pin_mux_pkg::PIN_A2;
    localparam int A3 = pin_mux_pkg::PIN_A3;
    localparam int B3 = pin_mux_pkg::PIN_B3;
    localparam int B4 = pin_mux_pkg::PIN_B4;

    // plain gpio drive {out, oe}; inputs, analog and alternate give no drive
    function automatic logic [1:0] gpio_drive(input logic [3:0] cfg, input logic data);
        logic [1:0] r;
        r = 2'h0;
        if (cfg == pin_mux_pkg::CFG_OUT_PP)
            r = {data, 1'b1};
        else if (cfg == pin_mux_pkg::CFG_OUT_OD)
            r = {1'b0, ~data};
        return r;
    endfunction

    pin_sync_if pins ();
    assign pins.raw = {port_b_bit4_pin_in, port_b_bit3_pin_in, port_a_bit3_pin_in,
                       port_a_bit2_pin_in, port_a_bit1_pin_in};

    pin_input_sync u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .pins       (pins)
    );

    logic [3:0] cfg1, cfg2, cfg3;
    logic       rm2, rm3, rm4, en2, en3, en4, spi, twi, master;
    logic [4:0] lvl;
    assign cfg1   = port_a_low_config_register_in[pin_mux_pkg::CFG_BIT1_LSB +: pin_mux_pkg::CFG_W];
    assign cfg2   = port_a_low_config_register_in[pin_mux_pkg::CFG_BIT2_LSB +: pin_mux_pkg::CFG_W];
    assign cfg3   = port_a_low_config_register_in[pin_mux_pkg::CFG_BIT3_LSB +: pin_mux_pkg::CFG_W];
    assign rm2    = timer2_remap_register_in[pin_mux_pkg::REMAP_CH2];
    assign rm3    = timer2_remap_register_in[pin_mux_pkg::REMAP_CH3];
    assign rm4    = timer2_remap_register_in[pin_mux_pkg::REMAP_CH4];
    assign en2    = timer2_output_enable_register_in[pin_mux_pkg::TEN_CH2];
    assign en3    = timer2_output_enable_register_in[pin_mux_pkg::TEN_CH3];
    assign en4    = timer2_output_enable_register_in[pin_mux_pkg::TEN_CH4];
    assign spi    = serial2_mode_field_in == pin_mux_pkg::MODE_SPI;
    assign twi    = serial2_mode_field_in == pin_mux_pkg::MODE_TWI;
    assign master = serial2_spi_config_in[pin_mux_pkg::SPI_MASTER_BIT];
    assign lvl    = pins.level;

    // registered state: pad drive, peripheral inputs, flags
    logic [4:0] pin_out, pin_oe, next_pin_out, next_pin_oe;
    logic       usb, next_usb;
    logic [2:0] tcap, next_tcap;      // ch2, ch3, ch4
    logic       sda, scl, miso, sclk, ssel_n;
    logic       next_sda, next_scl, next_miso, next_sclk, next_ssel_n;
    logic       irq_c, irq_d, next_irq_c, next_irq_d;
    logic [4:0] gpio_lvl, next_gpio_lvl;

    // mux decode; the timer claims a pin first, the serial controller only when it is free
    always_comb begin
        logic       free1, free2;
        logic [1:0] g;
        free1        = ~en3 | rm3;
        free2        = ~en4 | rm4;
        g            = 2'h0;
        next_pin_out = '0;
        next_pin_oe  = '0;
        next_usb     = 1'b0;

        // port a bit1
        g = gpio_drive(cfg1, gpio_data_in[A1]);
        if (cfg1 == pin_mux_pkg::CFG_ANALOG) begin
            next_usb = USB_PRESENT;
        end else if (~rm3 && en3 && cfg1 == pin_mux_pkg::CFG_ALT_OUT) begin
            {next_pin_out[A1], next_pin_oe[A1]} = {timer2_channel3_in, 1'b1};
        end else if (twi && free1 && cfg1 == pin_mux_pkg::CFG_ALT_OD) begin
            next_pin_oe[A1] = ~serial2_twi_data_in;
        end else if (spi && ~master && free1 && cfg1 == pin_mux_pkg::CFG_ALT_OUT) begin
            {next_pin_out[A1], next_pin_oe[A1]} = {serial2_spi_slave_out_master_in_in, 1'b1};
        end else begin
            {next_pin_out[A1], next_pin_oe[A1]} = g;
        end

        // port a bit2
        g = gpio_drive(cfg2, gpio_data_in[A2]);
        if (~rm4 && en4 && cfg2 == pin_mux_pkg::CFG_ALT_OUT) begin
            {next_pin_out[A2], next_pin_oe[A2]} = {timer2_channel4_in, 1'b1};
        end else if (twi && free2 && cfg2 == pin_mux_pkg::CFG_ALT_OD) begin
            next_pin_oe[A2] = ~serial2_twi_clock_in;
        end else if (spi && master && free2 && cfg2 == pin_mux_pkg::CFG_ALT_OUT) begin
            {next_pin_out[A2], next_pin_oe[A2]} = {serial2_spi_clock_in, 1'b1};
        end else begin
            {next_pin_out[A2], next_pin_oe[A2]} = g;
        end

        // port a bit3
        g = gpio_drive(cfg3, gpio_data_in[A3]);
        if (~rm2 && en2 && cfg3 == pin_mux_pkg::CFG_ALT_OUT) begin
            {next_pin_out[A3], next_pin_oe[A3]} = {timer2_channel2_in, 1'b1};
        end else begin
            {next_pin_out[A3], next_pin_oe[A3]} = g;
        end

        // port b remap counterparts; their serial 1 functions live elsewhere
        g = gpio_drive(port_b_bit3_cfg_in, gpio_data_in[B3]);
        if (rm3 && en3 && port_b_bit3_cfg_in == pin_mux_pkg::CFG_ALT_OUT) begin
            {next_pin_out[B3], next_pin_oe[B3]} = {timer2_channel3_in, 1'b1};
        end else begin
            {next_pin_out[B3], next_pin_oe[B3]} = g;
        end
        g = gpio_drive(port_b_bit4_cfg_in, gpio_data_in[B4]);
        if (rm4 && en4 && port_b_bit4_cfg_in == pin_mux_pkg::CFG_ALT_OUT) begin
            {next_pin_out[B4], next_pin_oe[B4]} = {timer2_channel4_in, 1'b1};
        end else begin
            {next_pin_out[B4], next_pin_oe[B4]} = g;
        end

        // capture inputs; ch2 remapped target is another pin, so it reads low here
        next_tcap[0] = rm2 ? 1'b0 : lvl[A3];
        next_tcap[1] = rm3 ? lvl[B3] : lvl[A1];
        next_tcap[2] = rm4 ? lvl[B4] : lvl[A2];

        // serial 2 inputs, idle levels when the mode does not use the pin
        next_sda    = twi ? lvl[A1] : pin_mux_pkg::IDLE_HIGH;
        next_scl    = twi ? lvl[A2] : pin_mux_pkg::IDLE_HIGH;
        next_miso   = (spi && master) ? lvl[A1] : pin_mux_pkg::IDLE_LOW;
        next_sclk   = (spi && ~master) ? lvl[A2] : pin_mux_pkg::IDLE_LOW;
        next_ssel_n = (spi && ~master) ? lvl[A3] : pin_mux_pkg::IDLE_HIGH;

        // out-of-range selects read low rather than an undefined bit
        next_irq_c = (interrupt_c_pin_select_in < 3'(pin_mux_pkg::NUM_PINS)) ?
                     lvl[interrupt_c_pin_select_in] : 1'b0;
        next_irq_d = (interrupt_d_pin_select_in < 3'(pin_mux_pkg::NUM_PINS)) ?
                     lvl[interrupt_d_pin_select_in] : 1'b0;
        next_gpio_lvl = lvl;
    end

    // registering every output keeps pad and peripheral timing one cycle, glitch free
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_out  <= pin_mux_pkg::PIN_OUT_RST;
            pin_oe   <= pin_mux_pkg::PIN_OE_RST;
            usb      <= 1'b0;
            tcap     <= '0;
            sda      <= pin_mux_pkg::IDLE_HIGH;
            scl      <= pin_mux_pkg::IDLE_HIGH;
            miso     <= pin_mux_pkg::IDLE_LOW;
            sclk     <= pin_mux_pkg::IDLE_LOW;
            ssel_n   <= pin_mux_pkg::IDLE_HIGH;
            irq_c    <= 1'b0;
            irq_d    <= 1'b0;
            gpio_lvl <= '0;
        end else if (ce_in) begin
            pin_out  <= next_pin_out;
            pin_oe   <= next_pin_oe;
            usb      <= next_usb;
            tcap     <= next_tcap;
            sda      <= next_sda;
            scl      <= next_scl;
            miso     <= next_miso;
            sclk     <= next_sclk;
            ssel_n   <= next_ssel_n;
            irq_c    <= next_irq_c;
            irq_d    <= next_irq_d;
            gpio_lvl <= next_gpio_lvl;
        end
    end

    // output wiring, all from flops
    assign {port_b_bit4_pin_out, port_b_bit3_pin_out, port_a_bit3_pin_out, port_a_bit2_pin_out,
            port_a_bit1_pin_out} = pin_out;
    assign {port_b_bit4_pin_oe_out, port_b_bit3_pin_oe_out, port_a_bit3_pin_oe_out, port_a_bit2_pin_oe_out,
            port_a_bit1_pin_oe_out} = pin_oe;
    assign usb_plus_line_out      = usb;
    assign {timer2_channel4_out, timer2_channel3_out, timer2_channel2_out} = tcap;
    assign serial2_twi_data_out   = sda;
    assign serial2_twi_clock_out  = scl;
    assign serial2_spi_slave_out_master_in_out = miso;
    assign serial2_spi_clock_out  = sclk;
    assign serial2_spi_slave_select_n_out = ssel_n;
    assign external_interrupt_c_out = irq_c;
    assign external_interrupt_d_out = irq_d;
    assign gpio_level_out         = gpio_lvl;
endmodule // port_a_low_pin_function_mux
